// ---- src/bvp_pkg.sv ----
// shared constants and types for the buck voltage page register bank
package bvp_pkg;
  localparam int         ADDR_W            = 9;
  localparam int         DATA_W            = 8;
  localparam int         CODE_W            = 7;
  // full register addresses (page folded in)
  localparam logic [8:0] ADDR_BASE         = 9'h0d5;
  localparam logic [8:0] ADDR_CEILING      = 9'h0d6;
  localparam logic [8:0] ADDR_DVC_STATUS   = 9'h0d7;
  localparam logic [8:0] ADDR_SETTING_A    = 9'h0d8;
  localparam logic [8:0] ADDR_SETTING_B    = 9'h0d9;
  localparam logic [8:0] ADDR_PAGE_CONTROL = 9'h100;
  localparam logic [8:0] ADDR_OTP_CONTROL  = 9'h101;
  localparam logic [8:0] ADDR_IF_CONFIG    = 9'h105;
  // page control fields
  localparam int         PC_REVERT_BIT     = 7;
  localparam int         PC_WMODE_BIT      = 6;
  localparam logic [2:0] PAGE_ZERO         = 3'h0;
  localparam logic [2:0] PAGE_SPI_MAX      = 3'h2;
  // otp control fields (own layout)
  localparam int         OTP_DONE_BIT      = 0;
  localparam int         OTP_MODE_BIT      = 1;
  localparam int         OTP_MARGIN_BIT    = 2;
  // interface config fields
  localparam int         IF_DIR_POL_BIT    = 3;
  localparam int         IF_CPHA_BIT       = 2;
  localparam int         IF_CPOL_BIT       = 1;
  localparam int         IF_SEL_POL_BIT    = 0;
  localparam logic [3:0] IF_BASE_UNPROG    = 4'h0;
  localparam logic [3:0] IF_BASE_DEFAULT   = 4'hd;
  localparam logic [7:0] DEV_ADDR_WRITE_LO = 8'hd0;
  localparam logic [7:0] DEV_ADDR_READ_LO  = 8'hd1;
  localparam logic [7:0] DEV_ADDR_WRITE_HI = 8'hd2;
  localparam logic [7:0] DEV_ADDR_READ_HI  = 8'hd3;
  // reset values
  localparam logic [7:0] RST_CEILING       = 8'h7f;
  localparam logic [7:0] RST_SETTING       = 8'h46;
  localparam logic [6:0] RST_BASE          = 7'h46;
  // host-side command port offsets
  localparam logic [3:0] HC_CMD            = 4'h0;
  localparam logic [3:0] HC_REG_ADDR       = 4'h1;
  localparam logic [3:0] HC_WDATA          = 4'h2;
  localparam logic [3:0] HC_STATUS         = 4'h3;
  localparam logic [3:0] HC_RDATA          = 4'h4;
  localparam logic [3:0] HC_DEV_ADDR       = 4'h5;
  localparam logic [7:0] HC_CMD_WRITE      = 8'h01;
  localparam logic [7:0] HC_CMD_READ       = 8'h02;
  typedef enum logic [1:0] {BVP_IF_I2C, BVP_IF_SPI} bvp_if_t;
endpackage : bvp_pkg

// ---- src/bvp_link_if.sv ----
// register link between host processor and regulator register bank
`timescale 1ns/10ps
`default_nettype none
interface bvp_link_if;
  logic       req;      // one-cycle access strobe
  logic       wr;       // 1 write, 0 read
  logic       is_spi;   // 1 four-wire, 0 two-wire framing
  logic [7:0] dev_addr; // two-wire device address byte
  logic [7:0] addr;     // in-page offset
  logic [7:0] wdata;
  logic       ack;      // one-cycle answer pulse
  logic       nak;      // address not matched
  logic [7:0] rdata;
  modport device (input req, wr, is_spi, dev_addr, addr, wdata, output ack, nak, rdata);
  modport host   (output req, wr, is_spi, dev_addr, addr, wdata, input ack, nak, rdata);
endinterface : bvp_link_if
`default_nettype wire

// ---- src/bvp_page_map.sv ----
// page select and in-page offset to full register address
`timescale 1ns/10ps
`default_nettype none
module bvp_page_map (
  input  wire logic       is_spi,
  input  wire logic [2:0] page,
  input  wire logic       hi_dev,
  input  wire logic [7:0] offset,
  output logic      [8:0] full_addr,
  output logic            valid
);
  always_comb begin
    full_addr = {1'b0, offset};
    valid     = 1'b1;
    if (is_spi) begin
      // offset msb ignored: each spi page spans 128 registers
      case (page)
        3'h0:    full_addr = {2'b00, offset[6:0]};
        3'h1:    full_addr = {2'b01, offset[6:0]};
        3'h2:    full_addr = {2'b10, offset[6:0]};
        default: valid     = 1'b0;
      endcase
    end else begin
      if (page[1] || hi_dev) begin
        full_addr = {1'b1, offset};
        valid     = !offset[7];
      end
    end
  end
endmodule : bvp_page_map
`default_nettype wire

// ---- src/bvp_device.sv ----
// regulator register bank end of the link
`timescale 1ns/10ps
`default_nettype none
module bvp_device #(
  parameter logic [3:0] OTP_BASE_NIBBLE = 4'hd,
  parameter logic [3:0] OTP_IF_POLARITY = 4'h0
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  bvp_link_if.device       link,
  input  wire logic        pin_step_up,
  input  wire logic        pin_step_down,
  input  wire logic        select_second,
  output logic       [6:0] applied_code,
  output logic             low_power_sel,
  output logic             write_mode_repeat,
  output logic             otp_margin_read,
  output logic             otp_emul_mode
);
  typedef struct packed {
    logic [7:0] ceiling;
    logic [6:0] base;
    logic [6:0] pin_target;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic       revert;
    logic       wmode;
    logic [2:0] page;
    logic [2:0] otp;
    logic [7:0] ifcfg;
    logic       ack;
    logic       nak;
    logic [7:0] rdata;
    logic [6:0] applied;
    logic       lp;
  } bvp_dev_state_t;

  bvp_dev_state_t st_reg, st_next;
  logic [8:0]     full_addr;
  logic           map_valid;
  logic           addr_ok;
  logic           hi_dev;
  logic [7:0]     dev_base;
  logic [6:0]     sel_code;

  // unprogrammed nibble falls back to the hardware default
  assign dev_base = {(st_reg.ifcfg[7:4] == bvp_pkg::IF_BASE_UNPROG) ?
                     bvp_pkg::IF_BASE_DEFAULT : st_reg.ifcfg[7:4], 4'h0};
  assign hi_dev   = link.dev_addr[1];
  assign addr_ok  = link.is_spi ||
                    (link.dev_addr[7:2] == dev_base[7:2]
                     && link.dev_addr[0] == !link.wr);

  bvp_page_map u_map (
    .is_spi    (link.is_spi),
    .page      (st_reg.page),
    .hi_dev    (hi_dev),
    .offset    (link.addr),
    .full_addr (full_addr),
    .valid     (map_valid)
  );

  function automatic logic [6:0] clamp(input logic [6:0] c, input logic [6:0] lim);
    clamp = (c > lim) ? lim : c;
  endfunction : clamp

  always_comb begin
    st_next     = st_reg;
    st_next.ack = 1'b0;
    st_next.nak = 1'b0;
    // pin interface steps are relative to the base code
    if (pin_step_up && st_reg.pin_target != 7'h7f)
      st_next.pin_target = st_reg.pin_target + 7'h01;
    else if (pin_step_down && st_reg.pin_target != 7'h00)
      st_next.pin_target = st_reg.pin_target - 7'h01;
    if (link.req) begin
      if (!addr_ok || !map_valid) begin
        st_next.nak = 1'b1;
      end else begin
        st_next.ack = 1'b1;
        if (link.wr) begin
          case (full_addr)
            bvp_pkg::ADDR_BASE: begin
              st_next.base       = link.wdata[6:0];
              st_next.pin_target = link.wdata[6:0];
            end
            bvp_pkg::ADDR_CEILING:   st_next.ceiling = {1'b0, link.wdata[6:0]};
            bvp_pkg::ADDR_SETTING_A: st_next.set_a   = link.wdata;
            bvp_pkg::ADDR_SETTING_B: st_next.set_b   = link.wdata;
            bvp_pkg::ADDR_PAGE_CONTROL: begin
              st_next.revert = link.wdata[bvp_pkg::PC_REVERT_BIT];
              st_next.wmode  = link.wdata[bvp_pkg::PC_WMODE_BIT];
              st_next.page   = link.wdata[2:0];
            end
            bvp_pkg::ADDR_OTP_CONTROL: begin
              st_next.otp[bvp_pkg::OTP_MODE_BIT]   = link.wdata[bvp_pkg::OTP_MODE_BIT];
              st_next.otp[bvp_pkg::OTP_MARGIN_BIT] = link.wdata[bvp_pkg::OTP_MARGIN_BIT];
              // clear wins; leaving emulated read mode clears even when done is written
              if (!link.wdata[bvp_pkg::OTP_MODE_BIT])
                st_next.otp[bvp_pkg::OTP_DONE_BIT] = 1'b0;
              else if (link.wdata[bvp_pkg::OTP_DONE_BIT])
                st_next.otp[bvp_pkg::OTP_DONE_BIT] = 1'b1;
            end
            default: ;
          endcase
        end else begin
          case (full_addr)
            bvp_pkg::ADDR_BASE:         st_next.rdata = {1'b0, st_reg.base};
            bvp_pkg::ADDR_CEILING:      st_next.rdata = {1'b0, st_reg.ceiling[6:0]};
            bvp_pkg::ADDR_DVC_STATUS:   st_next.rdata = {1'b0, st_reg.pin_target};
            bvp_pkg::ADDR_SETTING_A:    st_next.rdata = st_reg.set_a;
            bvp_pkg::ADDR_SETTING_B:    st_next.rdata = st_reg.set_b;
            bvp_pkg::ADDR_PAGE_CONTROL: st_next.rdata = {st_reg.revert, st_reg.wmode,
                                                         3'h0, st_reg.page};
            bvp_pkg::ADDR_OTP_CONTROL:  st_next.rdata = {5'h00, st_reg.otp};
            bvp_pkg::ADDR_IF_CONFIG:    st_next.rdata = st_reg.ifcfg;
            default:                    st_next.rdata = 8'h00;
          endcase
        end
        // revert applies after the access, overriding a page write in it
        if (st_next.revert)
          st_next.page = bvp_pkg::PAGE_ZERO;
      end
    end
    sel_code        = select_second ? st_reg.set_b[6:0] : st_reg.set_a[6:0];
    st_next.lp      = select_second ? st_reg.set_b[7] : st_reg.set_a[7];
    // linear code, applied value never above the ceiling
    st_next.applied = clamp(sel_code, st_reg.ceiling[6:0]);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg            <= '0;
      st_reg.ceiling    <= bvp_pkg::RST_CEILING;
      st_reg.base       <= bvp_pkg::RST_BASE;
      st_reg.pin_target <= bvp_pkg::RST_BASE;
      st_reg.set_a      <= bvp_pkg::RST_SETTING;
      st_reg.set_b      <= bvp_pkg::RST_SETTING;
      st_reg.ifcfg      <= {OTP_BASE_NIBBLE, OTP_IF_POLARITY};
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.ack          = st_reg.ack;
  assign link.nak          = st_reg.nak;
  assign link.rdata        = st_reg.rdata;
  assign applied_code      = st_reg.applied;
  assign low_power_sel     = st_reg.lp;
  assign write_mode_repeat = st_reg.wmode;
  assign otp_margin_read   = st_reg.otp[bvp_pkg::OTP_MARGIN_BIT];
  assign otp_emul_mode     = st_reg.otp[bvp_pkg::OTP_MODE_BIT];
endmodule : bvp_device
`default_nettype wire

// ---- src/bvp_host.sv ----
// host processor end: software command port driving the register link
`timescale 1ns/10ps
`default_nettype none
module bvp_host (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [3:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  output logic            spi_mode,
  bvp_link_if.host        link
);
  typedef enum logic [1:0] {H_IDLE, H_WAIT} bvp_hstate_t;
  typedef struct packed {
    bvp_hstate_t fsm;
    logic [7:0]  reg_addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  dev_base;
    logic        spi;
    logic        done;
    logic        nak;
    logic        req;
    logic        wr;
    logic [7:0]  sw_rdata;
  } bvp_host_state_t;

  bvp_host_state_t st_reg, st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.req = 1'b0;
    if (sw_wr) begin
      case (sw_addr)
        bvp_pkg::HC_REG_ADDR: st_next.reg_addr = sw_wdata;
        bvp_pkg::HC_WDATA:    st_next.wdata    = sw_wdata;
        bvp_pkg::HC_DEV_ADDR: begin
          // bit1 kept: it picks the upper address pair for pages 2 and 3
          st_next.dev_base = {sw_wdata[7:1], 1'b0};
          st_next.spi      = sw_wdata[0];
        end
        bvp_pkg::HC_CMD: begin
          // new commands while busy are dropped
          if (st_reg.fsm == H_IDLE && (sw_wdata == bvp_pkg::HC_CMD_WRITE
                                       || sw_wdata == bvp_pkg::HC_CMD_READ)) begin
            st_next.req  = 1'b1;
            st_next.wr   = (sw_wdata == bvp_pkg::HC_CMD_WRITE);
            st_next.done = 1'b0;
            st_next.nak  = 1'b0;
            st_next.fsm  = H_WAIT;
          end
        end
        default: ;
      endcase
    end
    st_next.sw_rdata = 8'h00;
    if (sw_rd) begin
      case (sw_addr)
        bvp_pkg::HC_REG_ADDR: st_next.sw_rdata = st_reg.reg_addr;
        bvp_pkg::HC_WDATA:    st_next.sw_rdata = st_reg.wdata;
        bvp_pkg::HC_STATUS:   st_next.sw_rdata = {5'h00, st_reg.fsm == H_WAIT,
                                                  st_reg.nak, st_reg.done};
        bvp_pkg::HC_RDATA:    st_next.sw_rdata = st_reg.rdata;
        bvp_pkg::HC_DEV_ADDR: st_next.sw_rdata = {st_reg.dev_base[7:1], st_reg.spi};
        default:              st_next.sw_rdata = 8'h00;
      endcase
    end
    case (st_reg.fsm)
      H_IDLE: ;
      H_WAIT: begin
        if (link.ack || link.nak) begin
          st_next.fsm  = H_IDLE;
          st_next.done = 1'b1;
          st_next.nak  = link.nak;
          if (link.ack && !st_reg.wr)
            st_next.rdata = link.rdata;
        end
      end
      default: st_next.fsm = H_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg          <= '0;
      st_reg.fsm      <= H_IDLE;
      st_reg.dev_base <= bvp_pkg::DEV_ADDR_WRITE_LO;
    end else begin
      st_reg <= st_next;
    end
  end

  // page 2/3 offsets use the upper address pair; read sets lsb
  assign link.req      = st_reg.req;
  assign link.wr       = st_reg.wr;
  assign link.is_spi   = st_reg.spi;
  assign link.dev_addr = st_reg.dev_base | {6'h00, 1'b0, !st_reg.wr};
  assign link.addr     = st_reg.reg_addr;
  assign link.wdata    = st_reg.wdata;
  assign sw_rdata      = st_reg.sw_rdata;
  assign spi_mode      = st_reg.spi;
endmodule : bvp_host
`default_nettype wire

// ---- tb/bvp_link_props.sv ----
// link checker: answer timing, refusals and fixed read values on the register link
`timescale 1ns/10ps
`default_nettype none
module bvp_link_props #(
  parameter logic [3:0] BASE_NIBBLE = 4'hd
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       req,
  input wire logic       wr,
  input wire logic       is_spi,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic       nak,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // a page-0 read of the ceiling that was accepted
  sequence ceil_rd;
    req && !wr && !is_spi && dev_addr == 8'hd1 && addr == 8'hd6 ##1 ack;
  endsequence
  // the high-page address always reaches the interface register
  sequence ifcfg_rd;
    req && !wr && !is_spi && dev_addr == 8'hd3 && addr == 8'h05 ##1 ack;
  endsequence

  ans_one_cycle_a: assert property (req |=> (ack ^ nak))
    else $error("link request not answered by exactly one of ack or nak");
  no_stray_ans_a: assert property ((ack || nak) |-> $past(req))
    else $error("link answer without a request one cycle before");
  one_outstanding_a: assert property (req |=> !req)
    else $error("link request issued while one is outstanding");
  nib_mismatch_a: assert property (req && !is_spi && dev_addr[7:4] != BASE_NIBBLE |=> nak)
    else $error("foreign two-wire address not refused");
  hi_page_range_a: assert property (req && !is_spi && dev_addr[7:4] == BASE_NIBBLE
                                    && dev_addr[1] && addr[7] |=> nak)
    else $error("high page offset above 0x7f not refused");
  ceil_rsvd_a: assert property (ceil_rd |-> rdata[7] == 1'b0)
    else $error("reserved ceiling bit read back nonzero");
  ifcfg_value_a: assert property (ifcfg_rd |-> rdata == 8'hd0)
    else $error("interface register read wrong value");
  write_quiet_a: assert property (ack && $past(wr) |-> $stable(rdata))
    else $error("read data changed on a write");
endmodule : bvp_link_props
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench: host end and register bank joined over the link
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic       clk;
  logic       resetn;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata;
  logic       sw_wr;
  logic       sw_rd;
  logic [7:0] sw_rdata;
  logic       spi_mode;
  logic       pin_step_up;
  logic       pin_step_down;
  logic       select_second;
  logic [6:0] applied_code;
  logic       low_power_sel;
  logic       write_mode_repeat;
  logic       otp_margin_read;
  logic       otp_emul_mode;
  int         fail_count;
  int         n_compared;
  int         cyc;
  logic [7:0] rd;
  logic [7:0] st;

  bvp_link_if link ();
  bvp_host bvp_host_i (.clk(clk), .resetn(resetn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .spi_mode(spi_mode), .link(link));
  bvp_device bvp_device_i (.clk(clk), .resetn(resetn), .link(link), .pin_step_up(pin_step_up),
    .pin_step_down(pin_step_down), .select_second(select_second), .applied_code(applied_code),
    .low_power_sel(low_power_sel), .write_mode_repeat(write_mode_repeat),
    .otp_margin_read(otp_margin_read), .otp_emul_mode(otp_emul_mode));
  bvp_link_props bvp_link_props_i (.clk(clk), .resetn(resetn), .req(link.req), .wr(link.wr),
    .is_spi(link.is_spi), .dev_addr(link.dev_addr), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .nak(link.nak), .rdata(link.rdata));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8

  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    sw_wr    <= 1'b1;
    sw_addr  <= a;
    sw_wdata <= d;
    @(posedge clk);
    sw_wr    <= 1'b0;
  endtask : sw_write

  // read data stand only in the cycle after the strobe is taken
  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    sw_rd   <= 1'b1;
    sw_addr <= a;
    @(posedge clk);
    sw_rd   <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_read

  // dev carries base address bits, bit1 high page, bit0 four-wire framing
  task automatic xfer(input logic w, input logic [7:0] dev, input logic [7:0] a,
                      input logic [7:0] d, input logic exp_nak);
    sw_write(bvp_pkg::HC_DEV_ADDR, dev);
    sw_write(bvp_pkg::HC_REG_ADDR, a);
    sw_write(bvp_pkg::HC_WDATA, d);
    sw_write(bvp_pkg::HC_CMD, w ? bvp_pkg::HC_CMD_WRITE : bvp_pkg::HC_CMD_READ);
    st = 8'h04;
    for (int i = 0; i < 20 && (st[2] || st[1:0] == 2'b00); i++)
      sw_read(bvp_pkg::HC_STATUS, st);
    sw_read(bvp_pkg::HC_RDATA, rd);
    // busy clear and done set, so a hung command cannot slip through
    check8(st, {6'h00, exp_nak, 1'b1});
    repeat (2) @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, dev, a, d, 1'b0);
  endtask : wr

  task automatic rdc(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] exp);
    xfer(1'b0, dev, a, 8'h00, 1'b0);
    check8(rd, exp);
  endtask : rdc

  task automatic t_reset_values;
    rdc(8'hd0, 8'hd6, 8'h7f);
    rdc(8'hd0, 8'hd8, 8'h46);
    rdc(8'hd0, 8'hd9, 8'h46);
    rdc(8'hd0, 8'hd7, 8'h46);
    rdc(8'hd2, 8'h05, 8'hd0);
    check8({1'b0, applied_code}, 8'h46);
  endtask : t_reset_values

  task automatic t_settings;
    wr(8'hd0, 8'hd6, 8'hff);
    rdc(8'hd0, 8'hd6, 8'h7f);
    wr(8'hd0, 8'hd8, 8'hd0);
    check8({1'b0, applied_code}, 8'h50);
    check8({7'h0, low_power_sel}, 8'h01);
    wr(8'hd0, 8'hd9, 8'h20);
    select_second <= 1'b1;
    repeat (3) @(posedge clk);
    check8({1'b0, applied_code}, 8'h20);
    check8({7'h0, low_power_sel}, 8'h00);
    wr(8'hd0, 8'hd6, 8'h18);
    select_second <= 1'b0;
    repeat (3) @(posedge clk);
    check8({1'b0, applied_code}, 8'h18);
  endtask : t_settings

  task automatic t_readonly;
    wr(8'hd0, 8'hd7, 8'h11);
    rdc(8'hd0, 8'hd7, 8'h46);
    wr(8'hd2, 8'h05, 8'h00);
    rdc(8'hd2, 8'h05, 8'hd0);
    wr(8'hd0, 8'hd5, 8'h10);
    rdc(8'hd0, 8'hd7, 8'h10);
    pin_step_up <= 1'b1;
    repeat (3) @(posedge clk);
    pin_step_up <= 1'b0;
    rdc(8'hd0, 8'hd7, 8'h13);
    pin_step_down <= 1'b1;
    repeat (20) @(posedge clk);
    pin_step_down <= 1'b0;
    rdc(8'hd0, 8'hd7, 8'h00);
  endtask : t_readonly

  task automatic t_pages;
    wr(8'hd2, 8'h00, 8'h43);
    check8({7'h0, write_mode_repeat}, 8'h01);
    rdc(8'hd0, 8'h05, 8'hd0);
    xfer(1'b0, 8'hd1, 8'h56, 8'h00, 1'b1);
    wr(8'hd2, 8'h00, 8'h01);
    rdc(8'hd1, 8'h56, 8'h18);
    check8({7'h0, spi_mode}, 8'h01);
    wr(8'hd2, 8'h00, 8'h82);
    rdc(8'hd2, 8'h00, 8'h80);
    rdc(8'hd0, 8'hd6, 8'h18);
    xfer(1'b0, 8'h50, 8'hd6, 8'h00, 1'b1);
    xfer(1'b0, 8'hd2, 8'h80, 8'h00, 1'b1);
  endtask : t_pages

  task automatic t_otp;
    wr(8'hd2, 8'h01, 8'h02);
    wr(8'hd2, 8'h01, 8'h03);
    rdc(8'hd2, 8'h01, 8'h03);
    check8({7'h0, otp_emul_mode}, 8'h01);
    wr(8'hd2, 8'h01, 8'h04);
    rdc(8'hd2, 8'h01, 8'h04);
    check8({7'h0, otp_margin_read}, 8'h01);
  endtask : t_otp

  initial begin
    resetn        = 1'b0;
    sw_addr       = 4'h0;
    sw_wdata      = 8'h00;
    sw_wr         = 1'b0;
    sw_rd         = 1'b0;
    pin_step_up   = 1'b0;
    pin_step_down = 1'b0;
    select_second = 1'b0;
    fail_count    = 0;
    n_compared    = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_reset_values();
    t_settings();
    t_readonly();
    t_pages();
    t_otp();
    tally_and_finish();
  end

  // a run still going at cycle 20000 ends here; a hung handshake fails the xfer status check
  initial cyc = 0;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
endmodule : tb
`default_nettype wire
